//--- rtl/aqs_down_counter.sv
// one down counter with mode, load register, load, step and arm commands
`timescale 1ns/1ps
`default_nettype none
module aqs_down_counter #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic mode_wr,
  input wire logic load_wr,
  input wire logic [W-1:0] wdata,
  input wire logic cmd_load,
  input wire logic cmd_step,
  input wire logic cmd_arm,
  input wire logic count_en,
  output logic [W-1:0] mode_q,
  output logic [W-1:0] load_q,
  output logic [W-1:0] count_q,
  output logic armed,
  output logic tc
);
  import aqs_pkg::*;

  // terminal count: an armed counter stepping from one to zero
  assign tc = armed && count_en && (count_q == {{(W-1){1'b0}}, 1'b1});

  // mode register holds what software wrote
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= '0;
    end else if (mode_wr) begin
      mode_q <= wdata;
    end
  end

  // load register; zero stands for a full wraparound period
  always_ff @(posedge clk) begin
    if (rst) begin
      load_q <= '0;
    end else if (load_wr) begin
      load_q <= wdata;
    end
  end

  // count: load beats step beats counting, reload at terminal count
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (cmd_load) begin
      count_q <= load_q;
    end else if (cmd_step) begin
      count_q <= count_q - 1'b1;
    end else if (tc) begin
      count_q <= load_q;
    end else if (armed && count_en) begin
      count_q <= count_q - 1'b1;
    end
  end

  // arm stays set so the run can be retriggered
  always_ff @(posedge clk) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (cmd_arm) begin
      armed <= 1'b1;
    end
  end
endmodule : aqs_down_counter
`default_nettype wire

//--- rtl/aqs_pkg.sv
// shared constants and types for the acquisition sample sequencer
package aqs_pkg;
  // register bus widths
  localparam int AW = 4;
  localparam int DW = 16;
  // register word indices
  localparam logic [AW-1:0] REG_CMD = 4'h0;
  localparam logic [AW-1:0] REG_DATA = 4'h1;
  localparam logic [AW-1:0] REG_CTRL = 4'h2;
  localparam logic [AW-1:0] REG_STATUS = 4'h3;
  localparam logic [AW-1:0] REG_FIFO = 4'h4;
  localparam logic [AW-1:0] REG_CONV_CLEAR = 4'h5;
  localparam logic [AW-1:0] REG_START = 4'h6;
  localparam logic [AW-1:0] REG_CG_MEM = 4'h7;
  localparam logic [AW-1:0] REG_CG_LOAD = 4'h8;
  localparam logic [AW-1:0] REG_CG_CLEAR = 4'h9;
  // control register fields
  localparam int CTRL_W = 5;
  localparam int CTRL_CWS = 0;
  localparam int CTRL_EN = 1;
  localparam int CTRL_IGATE = 2;
  localparam int CTRL_EXTPACE = 3;
  localparam int CTRL_PRETRIG = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  // status register fields
  localparam int ST_NOT_EMPTY = 0;
  localparam int ST_OVFL_N = 1;
  localparam int ST_OVRN_N = 2;
  localparam int ST_DONE = 3;
  localparam int ST_ACTIVE = 4;
  // channel-gain entry fields
  localparam int CG_CH_HI = 7;
  localparam int CG_CH_LO = 4;
  localparam int CG_GAIN_HI = 3;
  localparam int CG_GAIN_LO = 1;
  // counter command codes
  localparam logic [DW-1:0] CMD_SEL_IV_MODE = 16'hff03;
  localparam logic [DW-1:0] CMD_SEL_LO_MODE = 16'hff04;
  localparam logic [DW-1:0] CMD_SEL_HI_MODE = 16'hff05;
  localparam logic [DW-1:0] CMD_SEL_IV_LOAD = 16'hff0b;
  localparam logic [DW-1:0] CMD_SEL_LO_LOAD = 16'hff0c;
  localparam logic [DW-1:0] CMD_SEL_HI_LOAD = 16'hff0d;
  localparam logic [DW-1:0] CMD_LOAD_IV = 16'hff44;
  localparam logic [DW-1:0] CMD_LOAD_LO = 16'hff48;
  localparam logic [DW-1:0] CMD_LOADARM_HI = 16'hff70;
  localparam logic [DW-1:0] CMD_STEP_IV = 16'hfff3;
  localparam logic [DW-1:0] CMD_STEP_LO = 16'hfff4;
  localparam logic [DW-1:0] CMD_ARM_IV = 16'hff24;
  localparam logic [DW-1:0] CMD_ARM_LO = 16'hff28;
  // storage depths
  localparam int FIFO_DEPTH_DEF = 256;
  localparam int CG_DEPTH_DEF = 16;
  // data register destination selected by the last select command
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0, SEL_IV_MODE = 3'h1, SEL_IV_LOAD = 3'h2, SEL_LO_MODE = 3'h3,
    SEL_LO_LOAD = 3'h4, SEL_HI_MODE = 3'h5, SEL_HI_LOAD = 3'h6
  } aqs_dsel_t;
  // acquisition sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_PRE = 3'b010, ST_RUN = 3'b100
  } aqs_state_t;
endpackage : aqs_pkg

//--- rtl/aqs_sequencer.sv
// acquisition sample sequencer: counters, triggers, pacing, result fifo, error flags
//
// Contract
// [R01] host uses sample counts 2..65536, zero means 65536
// [R02] FF04 and FF0C select low mode, load
// [R03] FF48 loads, FFF4 steps, FF28 arms low counter
// [R04] host writes mode 1025 to low counter
// [R05] single mode ends at low counter zero
// [R06] chained: high steps per low zero, ends both
// [R07] chained low load is low bits minus one
// [R08] chained low load register then written zero
// [R09] FF05, FF0D select high; FF70 loads and arms
// [R10] high load is upper bits, maybe plus one
// [R11] host clears fifo, then loads channel-gain entry
// [R12] enable bit lets a trigger start conversions
// [R13] start strobe write acts as software trigger
// [R14] external trigger low pulse starts acquisition
// [R15] one conversion per interval until count zero
// [R16] error flag clear means acquisition halted
// [R17] host polls status and reads fifo
// [R18] external pacing falls start conversions after trigger
// [R19] external pacing stops at sample count zero
// [R20] pretrigger: second trigger starts sample counting
// [R21] host programs level gating for pretrigger
// [R22] entry bits 7:4 channel, 3:1 gain
// [R23] fifo overflow past depth clears overflow flag
// [R24] conversion while busy clears overrun flag
// [R25] clear strobe resets flags, fifo, done
// [R26] conversions pass only while enabled and running
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module aqs_sequencer #(
  parameter int FIFO_DEPTH = aqs_pkg::FIFO_DEPTH_DEF,
  parameter int CG_DEPTH = aqs_pkg::CG_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [aqs_pkg::AW-1:0] addr,
  input wire logic [aqs_pkg::DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [aqs_pkg::DW-1:0] rdata,
  input wire logic external_trigger_input_n,
  input wire logic external_conversion_input_n,
  input wire logic external_gate_input_n,
  input wire logic converter_busy,
  input wire logic result_valid,
  input wire logic [aqs_pkg::DW-1:0] result_data,
  output logic conv_start,
  output logic [3:0] mux_channel,
  output logic [2:0] mux_gain
);
  import aqs_pkg::*;

  localparam int FAW = $clog2(FIFO_DEPTH);
  localparam int CAW = $clog2(CG_DEPTH);

  logic [DW-1:0] rdata_reg;
  logic [CTRL_W-1:0] ctrl_reg;
  aqs_dsel_t dsel_reg;
  aqs_state_t state_reg, state_next;
  logic trig_s1, trig_s2, trig_s3, conv_s1, conv_s2, conv_s3, gate_s1, gate_s2;
  logic ovfl_reg, ovrn_reg, done_reg, conv_start_reg;
  logic [DW-1:0] fifo_mem [FIFO_DEPTH];
  logic [FAW-1:0] fifo_wp_reg, fifo_rp_reg;
  logic [FAW:0] fifo_cnt_reg;
  logic [CG_DEPTH_DEF > 0 ? 6 : 6:0] cg_mem [CG_DEPTH];
  logic [CAW:0] cg_wp_reg;
  logic [CAW-1:0] cg_rp_reg;
  logic [6:0] cg_out_reg;
  logic cmd_wr, data_wr, clear_wr, start_wr, fifo_rd;
  logic trig_evt, conv_fall, running, gated, conv_want, conv_go, ovrn_evt, ovfl_evt;
  logic term_evt, halt, err_any, fifo_full, fifo_pop, fifo_push, cg_adv;
  logic [DW-1:0] iv_mode, iv_load, iv_cnt, lo_mode, lo_load, lo_cnt, hi_mode, hi_load, hi_cnt;
  logic iv_armed, lo_armed, hi_armed, iv_tc, lo_tc, hi_tc;

  // bus strobes decoded from the address
  assign cmd_wr = wr && (addr == REG_CMD);
  assign data_wr = wr && (addr == REG_DATA);
  assign clear_wr = wr && (addr == REG_CONV_CLEAR);
  assign start_wr = wr && (addr == REG_START);
  assign fifo_rd = rd && (addr == REG_FIFO);
  assign rdata = rdata_reg;
  assign conv_start = conv_start_reg;
  assign mux_channel = cg_out_reg[6:3];
  assign mux_gain = cg_out_reg[2:0];

  // pin inputs pass two flops, the third only feeds edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      {trig_s1, trig_s2, trig_s3} <= 3'h7;
      {conv_s1, conv_s2, conv_s3} <= 3'h7;
      {gate_s1, gate_s2} <= 2'h3;
    end else begin
      {trig_s1, trig_s2, trig_s3} <= {external_trigger_input_n, trig_s1, trig_s2};
      {conv_s1, conv_s2, conv_s3} <= {external_conversion_input_n, conv_s1, conv_s2};
      {gate_s1, gate_s2} <= {external_gate_input_n, gate_s1};
    end
  end

  // control register: width select, enable, gates, pacing, pretrigger
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (wr && (addr == REG_CTRL)) begin
      ctrl_reg <= wdata[CTRL_W-1:0];
    end
  end

  // command writes pick the destination of later data writes
  always_ff @(posedge clk) begin
    if (rst) begin
      dsel_reg <= SEL_NONE;
    end else if (cmd_wr) begin
      case (wdata)
        CMD_SEL_IV_MODE: dsel_reg <= SEL_IV_MODE;
        CMD_SEL_IV_LOAD: dsel_reg <= SEL_IV_LOAD;
        CMD_SEL_LO_MODE: dsel_reg <= SEL_LO_MODE; // [R02]
        CMD_SEL_LO_LOAD: dsel_reg <= SEL_LO_LOAD; // [R02]
        CMD_SEL_HI_MODE: dsel_reg <= SEL_HI_MODE; // [R09]
        CMD_SEL_HI_LOAD: dsel_reg <= SEL_HI_LOAD; // [R09]
        default: dsel_reg <= dsel_reg;
      endcase
    end
  end

  // sample-interval counter, clocked by the system clock as timebase
  aqs_down_counter #(.W(DW)) u_iv (
    .clk(clk), .rst(rst),
    .mode_wr(data_wr && dsel_reg == SEL_IV_MODE), .load_wr(data_wr && dsel_reg == SEL_IV_LOAD),
    .wdata(wdata), .cmd_load(cmd_wr && wdata == CMD_LOAD_IV), .cmd_step(cmd_wr && wdata == CMD_STEP_IV),
    .cmd_arm(cmd_wr && wdata == CMD_ARM_IV), .count_en(running && !ctrl_reg[CTRL_EXTPACE]),
    .mode_q(iv_mode), .load_q(iv_load), .count_q(iv_cnt), .armed(iv_armed), .tc(iv_tc)
  );

  // low sample counter counts only issued conversions after the counting trigger
  aqs_down_counter #(.W(DW)) u_lo (
    .clk(clk), .rst(rst),
    .mode_wr(data_wr && dsel_reg == SEL_LO_MODE), .load_wr(data_wr && dsel_reg == SEL_LO_LOAD),
    .wdata(wdata), .cmd_load(cmd_wr && wdata == CMD_LOAD_LO), .cmd_step(cmd_wr && wdata == CMD_STEP_LO),
    .cmd_arm(cmd_wr && wdata == CMD_ARM_LO), .count_en(conv_go && state_reg == ST_RUN), // [R03]
    .mode_q(lo_mode), .load_q(lo_load), .count_q(lo_cnt), .armed(lo_armed), .tc(lo_tc)
  );

  // high sample counter steps on each low terminal count when chained
  aqs_down_counter #(.W(DW)) u_hi (
    .clk(clk), .rst(rst),
    .mode_wr(data_wr && dsel_reg == SEL_HI_MODE), .load_wr(data_wr && dsel_reg == SEL_HI_LOAD),
    .wdata(wdata), .cmd_load(cmd_wr && wdata == CMD_LOADARM_HI), .cmd_step(1'b0),
    .cmd_arm(cmd_wr && wdata == CMD_LOADARM_HI), .count_en(lo_tc && ctrl_reg[CTRL_CWS]), // [R06]
    .mode_q(hi_mode), .load_q(hi_load), .count_q(hi_cnt), .armed(hi_armed), .tc(hi_tc)
  );

  // triggers, pacing and termination
  assign trig_evt = start_wr || (trig_s3 && !trig_s2); // [R13] [R14]
  assign conv_fall = conv_s3 && !conv_s2; // [R18]
  assign running = (state_reg != ST_IDLE);
  assign gated = ctrl_reg[CTRL_IGATE] || !gate_s2; // [R12]
  assign conv_want = running && ctrl_reg[CTRL_EN] && !gated
                     && (ctrl_reg[CTRL_EXTPACE] ? conv_fall : iv_tc); // [R15] [R18] [R26]
  assign ovrn_evt = conv_want && converter_busy; // [R24]
  assign conv_go = conv_want && !converter_busy;
  assign term_evt = ctrl_reg[CTRL_CWS] ? hi_tc : (lo_tc && !ctrl_reg[CTRL_CWS]); // [R05] [R06]
  assign fifo_full = (fifo_cnt_reg == (FAW+1)'(FIFO_DEPTH));
  assign fifo_pop = fifo_rd && (fifo_cnt_reg != '0);
  assign fifo_push = result_valid && !fifo_full;
  assign ovfl_evt = result_valid && fifo_full; // [R23]
  assign err_any = ovfl_reg || ovrn_reg;
  assign halt = clear_wr || ovrn_evt || ovfl_evt || !ctrl_reg[CTRL_EN]; // [R16] [R25]

  // sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (trig_evt && ctrl_reg[CTRL_EN] && !err_any && !halt) begin // [R12]
          state_next = ctrl_reg[CTRL_PRETRIG] ? ST_PRE : ST_RUN; // [R20]
        end
      end
      ST_PRE: begin
        if (halt) begin
          state_next = ST_IDLE;
        end else if (trig_evt) begin
          state_next = ST_RUN; // [R20]
        end
      end
      ST_RUN: begin
        if (halt || term_evt) begin
          state_next = ST_IDLE; // [R05] [R19]
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // sequencer state register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // conversion start pulse to the converter
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_start_reg <= 1'b0;
    end else begin
      conv_start_reg <= conv_go; // [R15] [R26]
    end
  end

  // error and done flags; a set in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (rst) begin
      ovfl_reg <= 1'b0;
      ovrn_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      ovfl_reg <= ovfl_evt || (ovfl_reg && !clear_wr); // [R23] [R25]
      ovrn_reg <= ovrn_evt || (ovrn_reg && !clear_wr); // [R24] [R25]
      done_reg <= (term_evt && state_reg == ST_RUN) || (done_reg && !clear_wr); // [R25]
    end
  end

  // result fifo storage
  always_ff @(posedge clk) begin
    if (fifo_push) begin
      fifo_mem[fifo_wp_reg] <= result_data;
    end
  end

  // result fifo pointers; clear empties it
  always_ff @(posedge clk) begin
    if (rst || clear_wr) begin
      fifo_wp_reg <= '0;
      fifo_rp_reg <= '0;
      fifo_cnt_reg <= '0; // [R25]
    end else begin
      fifo_wp_reg <= fifo_wp_reg + FAW'(fifo_push);
      fifo_rp_reg <= fifo_rp_reg + FAW'(fifo_pop);
      fifo_cnt_reg <= fifo_cnt_reg + (FAW+1)'(fifo_push) - (FAW+1)'(fifo_pop);
    end
  end

  // channel-gain memory entries, appended after a memory clear
  always_ff @(posedge clk) begin
    if (wr && addr == REG_CG_MEM && cg_wp_reg < (CAW+1)'(CG_DEPTH)) begin
      cg_mem[cg_wp_reg[CAW-1:0]] <= wdata[CG_CH_HI:CG_GAIN_LO]; // [R22]
    end
  end

  // channel-gain pointers; each conversion steps to the next entry
  assign cg_adv = conv_go && (cg_wp_reg > (CAW+1)'(1));
  always_ff @(posedge clk) begin
    if (rst || (wr && addr == REG_CG_CLEAR)) begin
      cg_wp_reg <= '0;
      cg_rp_reg <= '0;
      cg_out_reg <= '0;
    end else begin
      if (wr && addr == REG_CG_MEM && cg_wp_reg < (CAW+1)'(CG_DEPTH)) begin
        cg_wp_reg <= cg_wp_reg + 1'b1;
      end
      if (wr && addr == REG_CG_LOAD) begin
        cg_rp_reg <= '0;
        cg_out_reg <= cg_mem[0];
      end else if (cg_adv) begin
        cg_rp_reg <= ({1'b0, cg_rp_reg} + 1'b1 == cg_wp_reg) ? '0 : cg_rp_reg + 1'b1;
        cg_out_reg <= cg_mem[({1'b0, cg_rp_reg} + 1'b1 == cg_wp_reg) ? '0 : cg_rp_reg + 1'b1];
      end
    end
  end

  // read data one cycle after the read strobe, zero elsewhere
  always_ff @(posedge clk) begin
    if (rst || !rd) begin
      rdata_reg <= '0;
    end else begin
      case (addr)
        REG_DATA: begin
          case (dsel_reg)
            SEL_IV_MODE: rdata_reg <= iv_mode;
            SEL_IV_LOAD: rdata_reg <= iv_load;
            SEL_LO_MODE: rdata_reg <= lo_mode;
            SEL_LO_LOAD: rdata_reg <= lo_load;
            SEL_HI_MODE: rdata_reg <= hi_mode;
            SEL_HI_LOAD: rdata_reg <= hi_load;
            default: rdata_reg <= '0;
          endcase
        end
        REG_CTRL: rdata_reg <= {{(DW-CTRL_W){1'b0}}, ctrl_reg};
        REG_STATUS: begin
          rdata_reg <= '0;
          rdata_reg[ST_NOT_EMPTY] <= (fifo_cnt_reg != '0);
          rdata_reg[ST_OVFL_N] <= !ovfl_reg; // [R16] [R23]
          rdata_reg[ST_OVRN_N] <= !ovrn_reg; // [R16] [R24]
          rdata_reg[ST_DONE] <= done_reg;
          rdata_reg[ST_ACTIVE] <= running;
        end
        REG_FIFO: rdata_reg <= (fifo_cnt_reg != '0) ? fifo_mem[fifo_rp_reg] : '0;
        default: rdata_reg <= '0;
      endcase
    end
  end

  // checks on the sequencing
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_sel_lo;
    cmd_wr && wdata == CMD_SEL_LO_LOAD |=> dsel_reg == SEL_LO_LOAD;
  endproperty
  a_sel_lo: assert property (p_sel_lo) else $error("load select not taken"); // [R02]

  property p_lo_load;
    cmd_wr && wdata == CMD_LOAD_LO && !data_wr |=> lo_cnt == $past(lo_load);
  endproperty
  a_lo_load: assert property (p_lo_load) else $error("low counter not loaded"); // [R03]

  property p_single_end;
    state_reg == ST_RUN && !ctrl_reg[CTRL_CWS] && lo_tc && !clear_wr |=> state_reg == ST_IDLE && done_reg;
  endproperty
  a_single_end: assert property (p_single_end) else $error("single run did not end"); // [R05]

  property p_chain_cont;
    state_reg == ST_RUN && ctrl_reg[CTRL_CWS] && lo_tc && !hi_tc && !halt |=> state_reg == ST_RUN;
  endproperty
  a_chain_cont: assert property (p_chain_cont) else $error("chained run ended early"); // [R06]

  property p_sw_trig;
    state_reg == ST_IDLE && start_wr && ctrl_reg[CTRL_EN] && !ctrl_reg[CTRL_PRETRIG] && !err_any && !halt
      |=> state_reg == ST_RUN;
  endproperty
  a_sw_trig: assert property (p_sw_trig) else $error("software trigger ignored"); // [R13]

  property p_conv_gate;
    conv_start |-> $past(running) && $past(ctrl_reg[CTRL_EN]);
  endproperty
  a_conv_gate: assert property (p_conv_gate) else $error("conversion outside a run"); // [R26]

  sequence s_idle_two;
    state_reg == ST_IDLE ##1 state_reg == ST_IDLE;
  endsequence
  property p_stop;
    s_idle_two |-> !conv_start;
  endproperty
  a_stop: assert property (p_stop) else $error("conversion after termination"); // [R19]

  property p_ovfl;
    ovfl_evt |=> ovfl_reg && state_reg == ST_IDLE ##1 ovfl_reg || $past(clear_wr);
  endproperty
  a_ovfl: assert property (p_ovfl) else $error("overflow not flagged"); // [R23]

  property p_clear;
    clear_wr && !ovfl_evt && !ovrn_evt && !result_valid |=> fifo_cnt_reg == '0 && !ovfl_reg && !ovrn_reg;
  endproperty
  a_clear: assert property (p_clear) else $error("clear strobe incomplete"); // [R25]

  sequence s_pre_entered;
    state_reg == ST_PRE && trig_evt && !halt;
  endsequence
  property p_pretrig;
    s_pre_entered |=> state_reg == ST_RUN;
  endproperty
  a_pretrig: assert property (p_pretrig) else $error("second trigger ignored"); // [R20]
endmodule : aqs_sequencer
`default_nettype wire

//--- verif/test_acquisition_sample_sequencer.sv
// self-checking bench for the acquisition sample sequencer
`timescale 1ns/1ps
`default_nettype none
module test_acquisition_sample_sequencer;
  import aqs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DW-1:0] rdata;
  logic trig_n = 1'b1;
  logic pace_n = 1'b1;
  logic gate_n = 1'b1;
  logic busy = 1'b0;
  logic rvalid = 1'b0;
  logic [DW-1:0] rdat = '0;
  logic conv_start;
  logic [3:0] mux_channel;
  logic [2:0] mux_gain;
  int miscompares = 0;
  int check_count = 0;
  int convs = 0;
  int cyc = 0;
  int inj = 0;
  int c;
  int iv;
  int cnt[3];
  bit busy_hold = 1'b0;
  int ct[$];
  logic [15:0] fq[$];
  logic [15:0] ent[2];
  logic [15:0] v;
  logic [15:0] rnd;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  aqs_sequencer dut_u (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .external_trigger_input_n(trig_n), .external_conversion_input_n(pace_n),
    .external_gate_input_n(gate_n), .converter_busy(busy), .result_valid(rvalid),
    .result_data(rdat), .conv_start(conv_start), .mux_channel(mux_channel), .mux_gain(mux_gain)
  );

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  function automatic logic [15:0] cbit(input int b);
    return 16'h0001 << b;
  endfunction : cbit

  // one write cycle, then an idle cycle so strobes never merge
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == REG_CONV_CLEAR) fq.delete();
    @(posedge clk);
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
    chk(nm, v, e);
    @(posedge clk);
  endtask : rchk

  task automatic cw(input logic [15:0] d);
    wr_reg(REG_CMD, d);
  endtask : cw

  task automatic dw(input logic [15:0] d);
    wr_reg(REG_DATA, d);
  endtask : dw

  // interval and sample counters set up the way host software does it
  task automatic prog(input int ivl, input logic [15:0] lo, input logic [15:0] hi, input bit chain);
    cw(CMD_SEL_IV_MODE);
    dw(16'h0000);
    cw(CMD_SEL_IV_LOAD);
    dw(16'h0002);
    cw(CMD_LOAD_IV);
    cw(CMD_STEP_IV);
    dw(16'(ivl));
    cw(CMD_ARM_IV);
    cw(CMD_SEL_LO_MODE);
    dw(16'h1025);
    rchk("lo_mode", REG_DATA, 16'h1025);
    cw(CMD_SEL_LO_LOAD);
    dw(lo);
    rchk("lo_load", REG_DATA, lo);
    cw(CMD_LOAD_LO);
    if (chain) begin
      dw(16'h0000);
      cw(CMD_ARM_LO);
      cw(CMD_SEL_HI_MODE);
      dw(16'h0025);
      rchk("hi_mode", REG_DATA, 16'h0025);
      cw(CMD_SEL_HI_LOAD);
      dw(hi);
      cw(CMD_LOADARM_HI);
    end else begin
      cw(CMD_STEP_LO);
      cw(CMD_ARM_LO);
    end
    wr_reg(REG_CONV_CLEAR, 16'h0000);
    wr_reg(REG_CG_LOAD, 16'h0000);
    convs = 0;
    ct.delete();
  endtask : prog

  task automatic trig;
    trig_n <= 1'b0;
    repeat (3) @(posedge clk);
    trig_n <= 1'b1;
    @(posedge clk);
  endtask : trig

  task automatic pace(input int n);
    repeat (n) begin
      pace_n <= 1'b0;
      repeat (2) @(posedge clk);
      pace_n <= 1'b1;
      repeat (5) @(posedge clk);
    end
  endtask : pace

  // wait for the run to end, then check count, spacing, status and results
  task automatic finish(input string nm, input int n, input int ivl);
    int i;
    for (i = 0; i < 4000 && convs < n; i++) @(posedge clk);
    if (convs < n) begin
      chk("conv_wait", 16'(convs), 16'(n));
      print_verdict();
    end
    repeat (40) @(posedge clk);
    chk("conv_count", 16'(convs), 16'(n));
    for (i = 1; ivl > 0 && i < ct.size(); i++) chk("interval", 16'(ct[i] - ct[i-1]), 16'(ivl));
    rchk("status_end", REG_STATUS, 16'h000f);
    while (fq.size() > 0) rchk("fifo", REG_FIFO, fq.pop_front());
    rchk("status_drained", REG_STATUS, 16'h000e);
    wr_reg(REG_CONV_CLEAR, 16'h0000);
    rchk("status_clear", REG_STATUS, 16'h0006);
    $display("test %s done", nm);
  endtask : finish

  // converter stand-in: busy and one result per start, plus injected results
  always @(posedge clk) begin
    cyc <= cyc + 1;
    busy <= busy_hold || conv_start === 1'b1;
    rnd = 16'($urandom);
    if (inj > 0 || conv_start === 1'b1) begin
      rvalid <= 1'b1;
      rdat <= rnd;
      if (fq.size() < FIFO_DEPTH_DEF) fq.push_back(rnd);
      if (inj > 0) inj <= inj - 1;
    end else begin
      rvalid <= 1'b0;
    end
    if (conv_start === 1'b1) begin
      convs++;
      ct.push_back(cyc);
    end
    if (ct.size() > 0 && cyc == ct[$] + 3) begin
      chk("mux", {9'h000, mux_channel, mux_gain}, {9'h000, ent[convs % 2][7:4], ent[convs % 2][3:1]});
    end
  end

  // main sequence
  initial begin
    void'($urandom(32'h7c28));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rchk("status_rst", REG_STATUS, 16'h0006);
    rchk("unmapped", 4'hf, 16'h0000);
    ent[0] = 16'($urandom) & 16'h00fe;
    ent[1] = 16'($urandom) & 16'h00fe;
    wr_reg(REG_CG_CLEAR, 16'h0000);
    wr_reg(REG_CG_MEM, ent[0]);
    wr_reg(REG_CG_MEM, ent[1]);
    wr_reg(REG_CG_LOAD, 16'h0000);
    chk("mux_load", {9'h000, mux_channel, mux_gain}, {9'h000, ent[0][7:4], ent[0][3:1]});
    $display("test reset done");
    // single counter, software and pin triggers
    cnt = '{2, 5, 3 + int'($urandom % 8)};
    foreach (cnt[i]) begin
      iv = 4 + int'($urandom % 5);
      prog(iv, 16'(cnt[i]), 16'h0000, 1'b0);
      wr_reg(REG_CTRL, cbit(CTRL_EN));
      rchk("ctrl", REG_CTRL, cbit(CTRL_EN));
      if (i == 1) trig();
      else wr_reg(REG_START, 16'h0000);
      finish("single", cnt[i] - 1, iv);
    end
    // chained counters ending on the high counter
    c = 2 + int'($urandom % 5);
    prog(6, 16'(c - 1), 16'h0001, 1'b1);
    wr_reg(REG_CTRL, cbit(CTRL_EN) | cbit(CTRL_CWS));
    wr_reg(REG_START, 16'h0000);
    finish("chained", c - 1, 6);
    // external pacing: refused without enable or trigger, stops at count
    prog(6, 16'h0004, 16'h0000, 1'b0);
    wr_reg(REG_CTRL, cbit(CTRL_EXTPACE));
    wr_reg(REG_START, 16'h0000);
    pace(2);
    chk("no_enable", 16'(convs), 16'h0000);
    wr_reg(REG_CTRL, cbit(CTRL_EN) | cbit(CTRL_EXTPACE));
    pace(2);
    chk("no_trigger", 16'(convs), 16'h0000);
    trig();
    pace(6);
    finish("external", 3, 0);
    // pretrigger: counting starts at the second trigger
    prog(6, 16'h0004, 16'h0000, 1'b0);
    wr_reg(REG_CTRL, cbit(CTRL_EN) | cbit(CTRL_PRETRIG));
    trig();
    for (c = 0; c < 200 && convs < 3; c++) @(posedge clk);
    chk("pre_wait", 16'(convs), 16'h0003);
    wr_reg(REG_START, 16'h0000);
    finish("pretrigger", 6, 6);
    // overrun halts the run and blocks triggers until cleared
    prog(6, 16'h0004, 16'h0000, 1'b0);
    busy_hold = 1'b1;
    wr_reg(REG_CTRL, cbit(CTRL_EN));
    wr_reg(REG_START, 16'h0000);
    repeat (20) @(posedge clk);
    busy_hold = 1'b0;
    rchk("status_overrun", REG_STATUS, 16'h0002);
    wr_reg(REG_START, 16'h0000);
    repeat (20) @(posedge clk);
    chk("halted", 16'(convs), 16'h0000);
    wr_reg(REG_CONV_CLEAR, 16'h0000);
    rchk("status_clear", REG_STATUS, 16'h0006);
    $display("test overrun done");
    // fifo fill to depth, then one more result overflows
    inj <= FIFO_DEPTH_DEF;
    @(posedge clk);
    for (c = 0; c < 400 && inj > 0; c++) @(posedge clk);
    chk("inj_wait", 16'(inj), 16'h0000);
    repeat (2) @(posedge clk);
    rchk("status_full", REG_STATUS, 16'h0007);
    inj <= 1;
    repeat (3) @(posedge clk);
    rchk("status_overflow", REG_STATUS, 16'h0005);
    while (fq.size() > 0) rchk("fifo_full", REG_FIFO, fq.pop_front());
    wr_reg(REG_CONV_CLEAR, 16'h0000);
    rchk("status_clear", REG_STATUS, 16'h0006);
    $display("test overflow done");
    print_verdict();
  end
endmodule : test_acquisition_sample_sequencer
`default_nettype wire
